// File: rtl/cck_bit_timer.sv
/*
 * core clock divider, time quantum prescaler and bit segment sequencer.
 * assumes the timing word and extension are held stable while run is high.
 */
`timescale 1ns/1ps
`default_nettype none
module cck_bit_timer (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [1:0] div_sel,
    input  wire logic [3:0] pext,
    input  wire logic [15:0] btim,
    output logic            core_tick,
    output logic            tq_tick,
    output logic            bit_start,
    output logic            sample_pt,
    output cck_pkg::cck_seg_e seg
);
    logic [2:0] div_cnt;
    logic [2:0] div_lim;
    logic [9:0] pre_cnt;
    logic [9:0] pre_lim;
    logic [3:0] seg_cnt;
    logic [3:0] first_time_segment_field;
    logic [3:0] second_time_segment_field;
    logic       core_fire;
    logic       tq_fire;

    assign div_lim   = 3'((4'h1 << div_sel) - 4'h1);  // [R22] [R2]
    assign pre_lim   = {pext, btim[5:0]};             // [R8]
    assign first_time_segment_field     = btim[cck_pkg::BT_FIRST_TIME_SEGMENT_FIELD +: 4];  // [R16]
    assign second_time_segment_field     = {1'b0, btim[cck_pkg::BT_SECOND_TIME_SEGMENT_FIELD +: 3]};
    assign core_fire = run && (div_cnt == div_lim);
    assign tq_fire   = core_fire && (pre_cnt == pre_lim);  // [R9]

    always_ff @(posedge clk) begin
        if (!rst_n || !run || core_fire) begin
            div_cnt <= 3'h0;
        end else begin
            div_cnt <= div_cnt + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !run || tq_fire) begin
            pre_cnt <= 10'h000;
        end else if (core_fire) begin
            pre_cnt <= pre_cnt + 10'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            seg     <= cck_pkg::SEG_SYNC;
            seg_cnt <= 4'h0;
        end else if (tq_fire) begin
            unique case (seg)
                cck_pkg::SEG_SYNC: begin  // [R11]
                    seg     <= cck_pkg::SEG_FIRST_TIME_SEGMENT_FIELD;
                    seg_cnt <= 4'h0;
                end
                cck_pkg::SEG_FIRST_TIME_SEGMENT_FIELD: begin  // [R10]
                    seg_cnt <= seg_cnt + 4'h1;
                    if (seg_cnt == first_time_segment_field) begin
                        seg     <= cck_pkg::SEG_SECOND_TIME_SEGMENT_FIELD;
                        seg_cnt <= 4'h0;
                    end
                end
                default: begin
                    seg_cnt <= seg_cnt + 4'h1;
                    if (seg_cnt == second_time_segment_field) begin
                        seg     <= cck_pkg::SEG_SYNC;
                        seg_cnt <= 4'h0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            core_tick <= 1'b0;
            tq_tick   <= 1'b0;
            bit_start <= 1'b0;
            sample_pt <= 1'b0;
        end else begin
            core_tick <= core_fire;
            tq_tick   <= tq_fire;
            bit_start <= tq_fire && (seg == cck_pkg::SEG_SYNC);
            sample_pt <= tq_fire && (seg == cck_pkg::SEG_FIRST_TIME_SEGMENT_FIELD) && (seg_cnt == first_time_segment_field);
        end
    end

    a_sync_one_tq: assert property (@(posedge clk) disable iff (!rst_n)  // [R11]
        run && tq_fire && seg == cck_pkg::SEG_SYNC |=> seg == cck_pkg::SEG_FIRST_TIME_SEGMENT_FIELD)
        else $error("sync segment not one quantum");
    a_sync_hold: assert property (@(posedge clk) disable iff (!rst_n)  // [R11]
        run && $past(run) && !tq_fire && seg == cck_pkg::SEG_SYNC |=> seg == cck_pkg::SEG_SYNC)
        else $error("sync segment left early");
    a_div_two: assert property (@(posedge clk) disable iff (!rst_n)  // [R22]
        run && div_sel == 2'h1 && core_fire |=> !core_fire ##1 (core_fire || !run))
        else $error("divide by two pacing wrong");
    logic [12:0] chk_gap;
    logic        chk_seen;

    // clock cycles since the last quantum
    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            chk_gap  <= 13'h0000;
            chk_seen <= 1'b0;
        end else if (tq_fire) begin
            chk_gap  <= 13'h0000;
            chk_seen <= 1'b1;
        end else begin
            chk_gap  <= chk_gap + 13'h0001;
        end
    end

    a_tq_presc: assert property (@(posedge clk) disable iff (!rst_n)  // [R9]
        tq_fire && chk_seen |-> {1'b0, chk_gap} + 14'h0001
            == ({4'h0, pre_lim} + 14'h0001) * ({11'h000, div_lim} + 14'h0001))
        else $error("quantum not on prescaler end");
    c_bit_done: cover property (@(posedge clk) disable iff (!rst_n) sample_pt ##[1:200] bit_start);
endmodule
`default_nettype wire

// File: rtl/cck_pkg.sv
/*
 * constants, types and register map of the can clock/timing/access block.
 * assumes a 20 MHz register clock and 16-bit register words.
 */
package cck_pkg;
    localparam int unsigned CLK_HZ      = 20_000_000;
    localparam int unsigned CORE_MAX_HZ = 25_000_000;
    localparam int unsigned NUM_OBJ     = 32;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h02;
    localparam logic [7:0] OFS_BTIM = 8'h06;
    localparam logic [7:0] OFS_TEST = 8'h0A;
    localparam logic [7:0] OFS_PEXT = 8'h0C;
    localparam logic [7:0] OFS_CDIV = 8'h0E;
    localparam logic [7:0] OFS_CREQ = 8'h10;
    localparam logic [7:0] OFS_CMSK = 8'h12;
    localparam logic [7:0] OFS_ARB2 = 8'h1A;
    localparam logic [7:0] OFS_MCTL = 8'h1C;
    localparam logic [7:0] OFS_DATA = 8'h1E;
    localparam logic [7:0] WIN_B_STRIDE = 8'h30;
    localparam logic [7:0] OFS_TXRQ = 8'h80;
    localparam logic [7:0] OFS_NDAT = 8'h90;
    localparam logic [7:0] OFS_IPND = 8'hA0;
    localparam logic [7:0] OFS_MVLD = 8'hB0;

    localparam logic [7:0]  RST_CTRL = 8'h01;
    localparam logic [15:0] RST_BTIM = 16'h2301;
    localparam logic [5:0]  RST_CREQ = 6'h01;
    localparam logic [3:0]  RST_PEXT = 4'h0;
    localparam logic [1:0]  RST_CDIV = 2'h0;
    localparam logic [6:0]  RST_TEST = 7'h00;

    localparam int CTRL_INIT   = 0;
    localparam int CTRL_UNLOCK = 6;
    localparam int CTRL_TEST   = 7;
    localparam int STAT_RXOK   = 4;
    localparam int STAT_FAST   = 5;
    localparam int TEST_RX     = 7;
    localparam int BT_SECOND_TIME_SEGMENT_FIELD    = 12;
    localparam int BT_FIRST_TIME_SEGMENT_FIELD    = 8;
    localparam int BT_SJW      = 6;
    localparam int CMSK_WR     = 7;
    localparam int CMSK_CLRINT = 3;
    localparam int ARB_VALID   = 15;
    localparam int ARB_DIR     = 13;
    localparam int ARB_ID      = 2;
    localparam int MCTL_NEWDAT = 15;
    localparam int MCTL_INTPND = 13;
    localparam int MCTL_TXRQ   = 8;

    typedef enum logic [1:0] {SEG_SYNC, SEG_FIRST_TIME_SEGMENT_FIELD, SEG_SECOND_TIME_SEGMENT_FIELD} cck_seg_e;
endpackage

// File: rtl/cck_top.sv
/*
 * register file, message ram, acceptance filter and bit timing of the can block.
 * assumes a single-strobe register master on clk and a protocol engine that
 * presents received frames on the same clock; can_rx is an asynchronous pin.
 */
// Operation
// [R1] core clock must not exceed 25 MHz
// [R2] core clock divided down from system clock
// [R3] read right after write returns new value
// [R4] divide by 2 needs one cycle gap
// [R5] divide 4 waits three, 8 waits seven
// [R6] wait only for same register read-back
// [R7] wait applies to read-modify-write too
// [R8] prescaler is extension value plus one
// [R9] quantum is core period times prescaler
// [R10] bit has four segments in sequence; the code runs three: sync, first, second
// [R11] sync segment is exactly one quantum
// [R12] propagation segment covers round-trip delay
// [R13] phase segments split evenly, second gets extra
// [R14] second phase segment at least two quanta
// [R15] timing word field weights and layout
// [R16] timing fields stored as length minus one
// [R17] command request write moves object data
// [R18] ram holds 32 objects, windowed access only
// [R19] object identifier filters received frames
// [R20] message handler registers are read only
// [R21] init plus unlock opens timing registers
// [R22] two-bit divider selects 1,2,4,8; resets 1
// [R23] jump width is min of four, phase1; the code never reads the jump width field
`timescale 1ns/1ps
`default_nettype none
module cck_top #(
    parameter int unsigned NUM_OBJ = cck_pkg::NUM_OBJ
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        can_rx,
    input  wire logic        rx_frame_valid,
    input  wire logic [10:0] rx_frame_id,
    input  wire logic [15:0] rx_frame_data,
    output logic             core_tick,
    output logic             tq_tick,
    output logic             bit_start,
    output logic             sample_point,
    output logic             tx_pending
);
    if (NUM_OBJ < 1 || NUM_OBJ > 32) begin : g_chk
        $error("NUM_OBJ must be 1 to 32");
    end

    logic [7:0]  ctrl_reg;
    logic        rxok_reg;
    logic [15:0] btim_reg;
    logic [6:0]  test_reg;
    logic [3:0]  pext_reg;
    logic [1:0]  cdiv_reg;
    logic        rx_meta;
    logic        rx_sync;
    logic [5:0]  creq_reg [2];
    logic [7:0]  cmsk_reg [2];
    logic [15:0] arb2_reg [2];
    logic [15:0] mctl_reg [2];
    logic [15:0] data_reg [2];
    logic [NUM_OBJ-1:0] obj_valid;
    logic [NUM_OBJ-1:0] obj_dir;
    logic [NUM_OBJ-1:0] obj_txrq;
    logic [NUM_OBJ-1:0] obj_newdat;
    logic [NUM_OBJ-1:0] obj_intpnd;
    logic [10:0] obj_id   [NUM_OBJ];
    logic [15:0] obj_data [NUM_OBJ];
    logic [31:0] txrq_w;
    logic [31:0] ndat_w;
    logic [31:0] ipnd_w;
    logic [31:0] mvld_w;
    logic        win_hit;
    logic        win_sel;
    logic [7:0]  woff;
    logic        unlocked;
    logic        xfer;
    logic        xfer_wr;
    logic [4:0]  xfer_idx;
    logic        hit_found;
    logic [4:0]  hit_idx;
    logic        stat_fast;
    logic [15:0] rd_mux;
    cck_pkg::cck_seg_e seg;

    assign win_sel  = (reg_addr[7:6] == 2'b01);
    assign woff     = win_sel ? reg_addr - cck_pkg::WIN_B_STRIDE : reg_addr;
    assign win_hit  = !reg_addr[7] && (woff >= cck_pkg::OFS_CREQ);
    assign unlocked = ctrl_reg[cck_pkg::CTRL_INIT] && ctrl_reg[cck_pkg::CTRL_UNLOCK];  // [R21]
    assign xfer     = reg_wr && win_hit && (woff == cck_pkg::OFS_CREQ)
                      && (reg_wdata[5:0] != 6'h00)
                      && ({26'h0, reg_wdata[5:0]} <= NUM_OBJ);  // [R17] [R18]
    assign xfer_idx = 5'(reg_wdata[5:0] - 6'h01);
    assign xfer_wr  = cmsk_reg[win_sel][cck_pkg::CMSK_WR];
    assign stat_fast = (cck_pkg::CLK_HZ >> cdiv_reg) > cck_pkg::CORE_MAX_HZ;  // [R1]

    // pin synchroniser for the bus receive level
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= can_rx;
            rx_sync <= rx_meta;
        end
    end

    // protocol registers; writes commit at once, so read-back is immediate
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_reg <= cck_pkg::RST_CTRL;
            test_reg <= cck_pkg::RST_TEST;
            cdiv_reg <= cck_pkg::RST_CDIV;  // [R22]
        end else if (reg_wr) begin  // [R3] [R6]
            if (reg_addr == cck_pkg::OFS_CTRL) begin
                ctrl_reg <= reg_wdata[7:0];
            end
            if (reg_addr == cck_pkg::OFS_TEST && ctrl_reg[cck_pkg::CTRL_TEST]) begin
                test_reg <= reg_wdata[6:0];
            end
            if (reg_addr == cck_pkg::OFS_CDIV) begin
                cdiv_reg <= reg_wdata[1:0];  // [R2] [R22]
            end
        end
    end

    // timing registers, writable only while held in init with unlock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            btim_reg <= cck_pkg::RST_BTIM;
            pext_reg <= cck_pkg::RST_PEXT;  // [R8]
        end else if (reg_wr && unlocked) begin  // [R21]
            if (reg_addr == cck_pkg::OFS_BTIM) begin
                btim_reg <= {1'b0, reg_wdata[14:0]};  // [R15] [R16]
            end
            if (reg_addr == cck_pkg::OFS_PEXT) begin
                pext_reg <= reg_wdata[3:0];
            end
        end
    end

    // sticky receive flag; a new frame wins over a clearing write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rxok_reg <= 1'b0;
        end else if (rx_frame_valid && hit_found) begin
            rxok_reg <= 1'b1;
        end else if (reg_wr && reg_addr == cck_pkg::OFS_STAT
                     && !reg_wdata[cck_pkg::STAT_RXOK]) begin
            rxok_reg <= 1'b0;
        end
    end

    // lowest-numbered valid receive object with matching identifier
    always_comb begin
        hit_found = 1'b0;
        hit_idx   = 5'h00;
        for (int i = NUM_OBJ - 1; i >= 0; i--) begin
            if (obj_valid[i] && !obj_dir[i] && obj_id[i] == rx_frame_id) begin  // [R19]
                hit_found = 1'b1;
                hit_idx   = 5'(i);
            end
        end
    end

    // window registers, loaded by software or by a read transfer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int w = 0; w < 2; w++) begin
                creq_reg[w] <= cck_pkg::RST_CREQ;
                cmsk_reg[w] <= 8'h00;
                arb2_reg[w] <= 16'h0000;
                mctl_reg[w] <= 16'h0000;
                data_reg[w] <= 16'h0000;
            end
        end else if (reg_wr && win_hit) begin
            unique case (woff)
                cck_pkg::OFS_CREQ: creq_reg[win_sel] <= reg_wdata[5:0];
                cck_pkg::OFS_CMSK: cmsk_reg[win_sel] <= reg_wdata[7:0];
                cck_pkg::OFS_ARB2: arb2_reg[win_sel] <= reg_wdata;
                cck_pkg::OFS_MCTL: mctl_reg[win_sel] <= reg_wdata;
                cck_pkg::OFS_DATA: data_reg[win_sel] <= reg_wdata;
                default: ;
            endcase
            if (xfer && !xfer_wr) begin  // [R17]
                arb2_reg[win_sel] <= {obj_valid[xfer_idx], 1'b0, obj_dir[xfer_idx],
                                      obj_id[xfer_idx], 2'b00};
                mctl_reg[win_sel] <= {obj_newdat[xfer_idx], 1'b0, obj_intpnd[xfer_idx],
                                      4'h0, obj_txrq[xfer_idx], 8'h00};
                data_reg[win_sel] <= obj_data[xfer_idx];
            end
        end
    end

    // message ram: window transfers, then frame acceptance (set wins)
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            obj_valid  <= '0;
            obj_dir    <= '0;
            obj_txrq   <= '0;
            obj_newdat <= '0;
            obj_intpnd <= '0;
            for (int i = 0; i < NUM_OBJ; i++) begin
                obj_id[i]   <= 11'h000;
                obj_data[i] <= 16'h0000;
            end
        end else begin
            if (xfer && xfer_wr) begin  // [R17] [R18]
                obj_valid[xfer_idx]  <= arb2_reg[win_sel][cck_pkg::ARB_VALID];
                obj_dir[xfer_idx]    <= arb2_reg[win_sel][cck_pkg::ARB_DIR];
                obj_id[xfer_idx]     <= arb2_reg[win_sel][cck_pkg::ARB_ID +: 11];
                obj_txrq[xfer_idx]   <= mctl_reg[win_sel][cck_pkg::MCTL_TXRQ];
                obj_newdat[xfer_idx] <= mctl_reg[win_sel][cck_pkg::MCTL_NEWDAT];
                obj_intpnd[xfer_idx] <= mctl_reg[win_sel][cck_pkg::MCTL_INTPND];
                obj_data[xfer_idx]   <= data_reg[win_sel];
            end else if (xfer && cmsk_reg[win_sel][cck_pkg::CMSK_CLRINT]) begin
                obj_intpnd[xfer_idx] <= 1'b0;
            end
            if (rx_frame_valid && hit_found) begin  // [R19]
                obj_newdat[hit_idx] <= 1'b1;
                obj_intpnd[hit_idx] <= 1'b1;
                obj_data[hit_idx]   <= rx_frame_data;
            end
        end
    end

    // handler views, objects 1..16 in the low word
    always_comb begin
        txrq_w = '0;
        ndat_w = '0;
        ipnd_w = '0;
        mvld_w = '0;
        txrq_w[NUM_OBJ-1:0] = obj_txrq;
        ndat_w[NUM_OBJ-1:0] = obj_newdat;
        ipnd_w[NUM_OBJ-1:0] = obj_intpnd;
        mvld_w[NUM_OBJ-1:0] = obj_valid;
    end

    always_comb begin
        rd_mux = 16'h0000;
        if (win_hit) begin
            unique case (woff)
                cck_pkg::OFS_CREQ: rd_mux = {10'h000, creq_reg[win_sel]};
                cck_pkg::OFS_CMSK: rd_mux = {8'h00, cmsk_reg[win_sel]};
                cck_pkg::OFS_ARB2: rd_mux = arb2_reg[win_sel];
                cck_pkg::OFS_MCTL: rd_mux = mctl_reg[win_sel];
                cck_pkg::OFS_DATA: rd_mux = data_reg[win_sel];
                default:           rd_mux = 16'h0000;
            endcase
        end else begin
            unique case ({reg_addr[7:2], 2'b00})
                cck_pkg::OFS_CTRL: rd_mux = reg_addr[1] ? {8'h00, 2'b00, stat_fast, rxok_reg,
                                            2'b00, 2'(seg)} : {8'h00, ctrl_reg};
                cck_pkg::OFS_STAT + 8'h02: rd_mux = reg_addr[1] ? btim_reg : 16'h0000;
                cck_pkg::OFS_TEST - 8'h02: rd_mux = reg_addr[1] ?
                                            {8'h00, rx_sync, test_reg} : 16'h0000;
                cck_pkg::OFS_PEXT: rd_mux = reg_addr[1] ? {14'h0000, cdiv_reg}
                                            : {12'h000, pext_reg};
                cck_pkg::OFS_TXRQ: rd_mux = reg_addr[1] ? txrq_w[31:16] : txrq_w[15:0];  // [R20]
                cck_pkg::OFS_NDAT: rd_mux = reg_addr[1] ? ndat_w[31:16] : ndat_w[15:0];
                cck_pkg::OFS_IPND: rd_mux = reg_addr[1] ? ipnd_w[31:16] : ipnd_w[15:0];
                cck_pkg::OFS_MVLD: rd_mux = reg_addr[1] ? mvld_w[31:16] : mvld_w[15:0];
                default:           rd_mux = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata  <= 16'h0000;
            tx_pending <= 1'b0;
        end else begin
            reg_rdata  <= reg_rd ? rd_mux : 16'h0000;
            tx_pending <= |obj_txrq;
        end
    end

    cck_bit_timer u_timer (
        .clk       (clk),
        .rst_n     (rst_n),
        .run       (!ctrl_reg[cck_pkg::CTRL_INIT]),
        .div_sel   (cdiv_reg),
        .pext      (pext_reg),
        .btim      (btim_reg),
        .core_tick (core_tick),
        .tq_tick   (tq_tick),
        .bit_start (bit_start),
        .sample_pt (sample_point),
        .seg       (seg)
    );

    logic        chk_xfer_q;
    logic [4:0]  chk_idx_q;
    logic [15:0] chk_data_q;
    logic        chk_hit_q;
    logic [4:0]  chk_hit_idx_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chk_xfer_q    <= 1'b0;
            chk_idx_q     <= 5'h00;
            chk_data_q    <= 16'h0000;
            chk_hit_q     <= 1'b0;
            chk_hit_idx_q <= 5'h00;
        end else begin
            chk_xfer_q    <= xfer && xfer_wr && !(rx_frame_valid && hit_found);
            chk_idx_q     <= xfer_idx;
            chk_data_q    <= data_reg[win_sel];
            chk_hit_q     <= rx_frame_valid && hit_found;
            chk_hit_idx_q <= hit_idx;
        end
    end

    a_ctrl_readback: assert property (@(posedge clk) disable iff (!rst_n)  // [R3]
        reg_wr && reg_addr == cck_pkg::OFS_CTRL ##1 reg_rd && reg_addr == cck_pkg::OFS_CTRL
        |=> reg_rdata == ($past(reg_wdata, 2) & 16'h00FF))
        else $error("control read-back stale");
    a_btim_locked: assert property (@(posedge clk) disable iff (!rst_n)  // [R21]
        reg_wr && reg_addr == cck_pkg::OFS_BTIM && !unlocked |=> $stable(btim_reg))
        else $error("timing word changed while locked");
    a_btim_write: assert property (@(posedge clk) disable iff (!rst_n)  // [R15]
        reg_wr && reg_addr == cck_pkg::OFS_BTIM && unlocked
        |=> btim_reg == ($past(reg_wdata) & 16'h7FFF))
        else $error("timing word not stored");
    a_cdiv_readback: assert property (@(posedge clk) disable iff (!rst_n)  // [R22]
        reg_wr && reg_addr == cck_pkg::OFS_CDIV ##1 reg_rd && reg_addr == cck_pkg::OFS_CDIV
        |=> reg_rdata == ($past(reg_wdata, 2) & 16'h0003))
        else $error("divider read-back wrong");
    a_xfer_store: assert property (@(posedge clk) disable iff (!rst_n)  // [R17]
        chk_xfer_q |-> obj_data[chk_idx_q] == chk_data_q)
        else $error("window write transfer lost");
    a_handler_ro: assert property (@(posedge clk) disable iff (!rst_n)  // [R20]
        reg_wr && reg_addr[7] |=> $stable(obj_valid) && $stable(obj_txrq))
        else $error("handler register took a write");
    a_accept_sets: assert property (@(posedge clk) disable iff (!rst_n)  // [R19]
        chk_hit_q |-> obj_newdat[chk_hit_idx_q] && obj_intpnd[chk_hit_idx_q])
        else $error("accepted frame not flagged");
    a_rxok_wins: assert property (@(posedge clk) disable iff (!rst_n)
        rx_frame_valid && hit_found |=> rxok_reg)
        else $error("receive flag lost against clear");

    c_xfer: cover property (@(posedge clk) disable iff (!rst_n) xfer && xfer_wr);
    c_accept: cover property (@(posedge clk) disable iff (!rst_n) rx_frame_valid && hit_found);
    c_readback: cover property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == cck_pkg::OFS_CTRL ##1 reg_rd);
    c_bits: cover property (@(posedge clk) disable iff (!rst_n) bit_start);
endmodule
`default_nettype wire

// File: sim/cck_bus_node.sv
/*
 * far-side bus node: hands received frames to the block and drives can_rx.
 * assumes send is a one-cycle request from the bench on clk.
 */
`timescale 1ns/1ps
`default_nettype none
module cck_bus_node (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        send,
    input  wire logic [10:0] id,
    input  wire logic [15:0] data,
    output logic             can_rx,
    output logic             rx_frame_valid,
    output logic      [10:0] rx_frame_id,
    output logic      [15:0] rx_frame_data
);
    // frame lines toggle when idle so stale values never look valid
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_frame_valid <= 1'b0;
            rx_frame_id    <= 11'h000;
            rx_frame_data  <= 16'h0000;
            can_rx         <= 1'b1;
        end else begin
            rx_frame_valid <= send;
            rx_frame_id    <= send ? id : ~rx_frame_id;
            rx_frame_data  <= send ? data : ~rx_frame_data;
            can_rx         <= ~send;
        end
    end
endmodule
`default_nettype wire

// File: sim/tb.sv
/*
 * self-checking bench for cck_top: register rows, reset, timing, objects.
 * assumes a 20 MHz clock and the register map of cck_pkg.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, send = 0;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, f_data = 16'h0000, reg_rdata, rx_d;
    logic [10:0] f_id = 11'h000, rx_id;
    logic        can_rx, rx_v, core_tick, tq_tick, bit_start, sample_point, tx_pending;
    int          mismatches = 0, checked = 0, cyc = 0, lag = 0;
    int          cnt[4] = '{default: 0};
    int          gap[4] = '{default: 0};
    logic [3:0]  p;
    logic [7:0]  ra[6] = '{8'h00, 8'h06, 8'h0C, 8'h0E, 8'h80, 8'h04};
    // timing row keeps segment advice
    logic [15:0] rw[6] = '{16'h0041, 16'h6FC0, 16'h0003, 16'h0003, 16'hFFFF, 16'h5A5A};
    logic [15:0] re[6] = '{16'h0041, 16'h6FC0, 16'h0003, 16'h0003, 16'h0000, 16'h0000};

    cck_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .can_rx(can_rx),
        .rx_frame_valid(rx_v), .rx_frame_id(rx_id), .rx_frame_data(rx_d),
        .core_tick(core_tick), .tq_tick(tq_tick), .bit_start(bit_start),
        .sample_point(sample_point), .tx_pending(tx_pending));
    cck_bus_node node (.clk(clk), .rst_n(rst_n), .send(send), .id(f_id), .data(f_data),
        .can_rx(can_rx), .rx_frame_valid(rx_v), .rx_frame_id(rx_id), .rx_frame_data(rx_d));

    always #25 clk = ~clk;
    assign p = {sample_point, bit_start, tq_tick, core_tick};
    // cycles between pulses, and sample point after bit start
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            cnt[i] <= p[i] ? 1 : cnt[i] + 1;
            if (p[i]) gap[i] <= cnt[i];
        end
        if (sample_point) lag <= cnt[2];
    end

    task automatic summarize();
        if (mismatches == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            wr(ra[i], rw[i]);
            if (i > 3) repeat (7) @(posedge clk);
            rd(ra[i], re[i]);
        end
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(8'h00, 16'h0001);
        @(posedge clk);
        #1 chk(reg_rdata, 16'h0000);
        rd(8'h0C, 16'h0000);
        rd(8'h0E, 16'h0000);
        rd(8'h0A, 16'h0080);
        wr(8'h06, 16'h1234);
        rd(8'h06, 16'h2301);
        wr(8'h00, 16'h0041);
        wr(8'h06, 16'h1201);
        wr(8'h0E, 16'h0001);
        @(posedge clk);
        rd(8'h0E, 16'h0001);
        wr(8'h00, 16'h0000);
        repeat (100) @(posedge clk);
        chk(16'(gap[0]), 16'h0002);
        chk(16'(gap[1]), 16'h0004);
        chk(16'(gap[2]), 16'h0018);
        chk(16'(lag), 16'h000C);
        wr(8'h1A, 16'h848C);
        wr(8'h1C, 16'h0000);
        wr(8'h12, 16'h0080);
        wr(8'h10, 16'h0005);
        send <= 1'b1;
        f_id <= 11'h123;
        f_data <= 16'hBEEF;
        @(posedge clk);
        send <= 1'b0;
        repeat (3) @(posedge clk);
        rd(8'h90, 16'h0010);
        rd(8'hB0, 16'h0010);
        wr(8'h12, 16'h0008);
        wr(8'h10, 16'h0005);
        rd(8'h1E, 16'hBEEF);
        rd(8'hA0, 16'h0000);
        wr(8'h1A, 16'hA000);
        wr(8'h1C, 16'h0100);
        wr(8'h12, 16'h0080);
        wr(8'h10, 16'h0020);
        rd(8'h82, 16'h8000);
        chk({15'h0000, tx_pending}, 16'h0001);
        summarize();
    end
endmodule
`default_nettype wire
